// [design/cal_mode_pkg.sv]
// constants for the calibration mode configuration block
package cal_mode_pkg;
  localparam int unsigned   ADDR_W          = 8;
  localparam int unsigned   DATA_W          = 8;
  localparam logic [7:0]    CAL_MODE_ADDR   = 8'h62;
  localparam logic [7:0]    CAL_MODE_RESET  = 8'h01;
  localparam logic [7:0]    CAL_MODE_WMASK  = 8'h0f;
  localparam int unsigned   BIT_FG_RUN      = 0;
  localparam int unsigned   BIT_BG_ON       = 1;
  localparam int unsigned   BIT_FG_OS       = 2;
  localparam int unsigned   BIT_BG_OS       = 3;
  localparam logic [7:0]    READ_IDLE       = 8'h00;
  localparam int unsigned   CLEAR_CYCLES_D  = 4;
  localparam int unsigned   FG_CYCLES_D     = 16;
endpackage

// [design/cal_edge_sync.sv]
// two-flop synchroniser with rising edge detect
`timescale 1ns/100ps
module cal_edge_sync
(
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic level_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta;
  logic sync;
  logic sync_d;

  // the first flop feeds only the second
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta   <= 1'b0;
      sync   <= 1'b0;
      sync_d <= 1'b0;
    end
    else
    begin
      meta   <= level_in;
      sync   <= meta;
      sync_d <= sync;
    end
  end

  assign level_out = sync;
  assign rise_out  = sync & ~sync_d;
endmodule // cal_edge_sync

// [design/cal_mode_config.sv]
// calibration mode configuration register and calibration sequencer
`timescale 1ns/100ps
module cal_mode_config
  import cal_mode_pkg::*;
#(
  parameter int unsigned CLEAR_CYCLES = CLEAR_CYCLES_D,
  parameter int unsigned FG_CYCLES    = FG_CYCLES_D
)
(
  input  wire logic              ref_clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  input  wire logic              cal_enable_in,
  output logic                   trim_clear_out,
  output logic                   foreground_trim_run,
  output logic                   fg_offset_trim_on,
  output logic                   background_trim_on,
  output logic                   bg_offset_trim_on,
  output logic                   fg_done_out
);
  initial
  begin
    if (CLEAR_CYCLES < 1 || FG_CYCLES < 1 || CLEAR_CYCLES > 4096 || FG_CYCLES > 4096)
      $error("cycle counts out of range");
  end

  typedef enum logic [3:0] {
    ST_HOLD  = 4'b0001,
    ST_CLEAR = 4'b0010,
    ST_FG    = 4'b0100,
    ST_RUN   = 4'b1000
  } cal_state_e;

  // --------------------------------------------------------------
  // register file
  // --------------------------------------------------------------
  logic [DATA_W-1:0] calibration_mode_config;
  logic [DATA_W-1:0] active_mode;
  logic              en_level;
  logic              en_rise;
  cal_state_e        state;
  cal_state_e        next_state;
  logic [12:0]       count;

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    return a == CAL_MODE_ADDR;
  endfunction

  // reserved bits are not stored so they always read zero
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      calibration_mode_config <= CAL_MODE_RESET;
    else if (reg_wr_in && hit(reg_addr_in))
      calibration_mode_config <= reg_wdata_in & CAL_MODE_WMASK;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      reg_rdata_out <= READ_IDLE;
    else if (reg_rd_in && hit(reg_addr_in))
      reg_rdata_out <= calibration_mode_config;
    else
      reg_rdata_out <= READ_IDLE;
  end

  // --------------------------------------------------------------
  // master enable and mode capture
  // --------------------------------------------------------------
  cal_edge_sync u_en_sync
  (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .level_in   (cal_enable_in),
    .level_out  (en_level),
    .rise_out   (en_rise)
  );

  // changes while enabled wait for the next enable rise
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      active_mode <= CAL_MODE_RESET;
    else if (en_rise)
      active_mode <= calibration_mode_config;
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_HOLD:  if (en_rise) next_state = ST_CLEAR;
      ST_CLEAR: if (count == 13'(CLEAR_CYCLES - 1))
                  next_state = active_mode[BIT_FG_RUN] ? ST_FG : ST_RUN;
      ST_FG:    if (count == 13'(FG_CYCLES - 1)) next_state = ST_RUN;
      ST_RUN:   next_state = ST_RUN;
      default:  next_state = ST_HOLD;
    endcase
    if (!en_level)
      next_state = ST_HOLD;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state <= ST_HOLD;
    else
      state <= next_state;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      count <= '0;
    else if (next_state != state)
      count <= '0;
    else
      count <= count + 13'd1;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      fg_done_out <= 1'b0;
    else if (state == ST_HOLD || state == ST_CLEAR)
      fg_done_out <= 1'b0;
    else if (state == ST_FG && next_state == ST_RUN)
      fg_done_out <= 1'b1;
  end

  // --------------------------------------------------------------
  // routine enables
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      trim_clear_out      <= 1'b0;
      foreground_trim_run <= 1'b0;
      fg_offset_trim_on   <= 1'b0;
      background_trim_on  <= 1'b0;
      bg_offset_trim_on   <= 1'b0;
    end
    else
    begin
      trim_clear_out      <= next_state == ST_CLEAR;
      foreground_trim_run <= next_state == ST_FG;
      // offset trims are gated by their parent routines
      fg_offset_trim_on   <= next_state == ST_FG && active_mode[BIT_FG_OS];
      background_trim_on  <= next_state == ST_RUN && active_mode[BIT_BG_ON];
      bg_offset_trim_on   <= next_state == ST_RUN && active_mode[BIT_BG_ON]
                             && active_mode[BIT_BG_OS];
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  reserved_zero_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    calibration_mode_config[7:4] == 4'h0) else $error("reserved bits stored");
  bgos_parent_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    bg_offset_trim_on |-> background_trim_on) else $error("bg offset without bg");
  fgos_parent_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    fg_offset_trim_on |-> foreground_trim_run) else $error("fg offset without fg");
  hold_idle_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !en_level |=> !trim_clear_out && !foreground_trim_run && !background_trim_on)
    else $error("calibration active while held");
  clear_first_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $rose(foreground_trim_run) |-> $past(trim_clear_out)) else $error("fg without clear");
  skip_fg_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    foreground_trim_run |-> active_mode[BIT_FG_RUN]) else $error("fg pass not skipped");
  bg_sel_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    background_trim_on |-> active_mode[BIT_BG_ON]) else $error("bg without select");
  capture_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    en_rise |=> active_mode == $past(calibration_mode_config)) else $error("mode not sampled");
  write_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    reg_wr_in && reg_addr_in == CAL_MODE_ADDR |=> calibration_mode_config[3:0]
    == $past(reg_wdata_in[3:0])) else $error("write lost");

  // --------------------------------------------------------------
  // read path and sequence timing checks
  // --------------------------------------------------------------
  // unmapped reads must not leak the mode byte
  read_other_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    reg_rd_in && reg_addr_in != CAL_MODE_ADDR |=> reg_rdata_out == READ_IDLE)
    else $error("unmapped read not zero");
  read_back_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    reg_rd_in && reg_addr_in == CAL_MODE_ADDR |=> reg_rdata_out == $past(calibration_mode_config))
    else $error("read data wrong");
  clear_start_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    en_rise |=> trim_clear_out)
    else $error("clear not started");
  done_after_fg_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $rose(fg_done_out) |-> $past(foreground_trim_run))
    else $error("done without fg pass");
  // a runaway counter would stretch the clear or the pass without limit
  clear_count_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    state == ST_CLEAR |-> count < 13'(CLEAR_CYCLES))
    else $error("clear too long");
  fg_count_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    state == ST_FG |-> count < 13'(FG_CYCLES))
    else $error("fg pass too long");
  run_hold_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !en_level |=> state == ST_HOLD)
    else $error("sequencer not held");
endmodule // cal_mode_config

// [sim/cal_mode_config_tb_top.sv]
// self-checking bench for the calibration mode configuration block
`timescale 1ns/100ps
module cal_mode_config_tb_top import cal_mode_pkg::*;;
  localparam int CLR = 3;
  localparam int FGC = 5;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] cap;
  logic [7:0] model_reg = CAL_MODE_RESET;
  logic       clr, fgr, fgo, bgn, bgo, done;
  int         fails = 0;
  int         n_checks = 0;
  int         cyc = 0;
  int         n;
  int         seed = 32'h2a7d_bcbf;

  always #5 clk = ~clk;

  cal_mode_config #(.CLEAR_CYCLES(CLR), .FG_CYCLES(FGC)) dut_u (
    .ref_clk_in(clk), .arst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .cal_enable_in(en), .trim_clear_out(clr), .foreground_trim_run(fgr),
    .fg_offset_trim_on(fgo), .background_trim_on(bgn), .bg_offset_trim_on(bgo),
    .fg_done_out(done));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // inputs change 1 ns after the edge, never on it
  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step;
    wr = 1'b0;
    if (a == CAL_MODE_ADDR) model_reg = d & 8'h0f;
  endtask

  task automatic rd_reg(input logic [7:0] a, input string nm);
    addr = a;
    rd = 1'b1;
    step;
    rd = 1'b0;
    chk(nm, (a == CAL_MODE_ADDR) ? model_reg : 8'h00, rdata);
  endtask

  // bounded: a stuck-high output cannot hang the run
  task automatic run_len(input int which, output int len);
    len = 0;
    while (len < 60 && ((which == 0) ? clr : fgr) === 1'b1)
    begin
      len++;
      step;
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      conclude;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("reset_outs", 8'h00, {2'b00, clr, fgr, fgo, bgn, bgo, done});
    rd_reg(CAL_MODE_ADDR, "reset_val");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      // software keeps the reserved bits at zero on every write
      wr_reg(8'($random(seed)), 8'($random(seed)) & 8'h0f);
      wr_reg(CAL_MODE_ADDR, 8'($random(seed)) & 8'h0f);
      rd_reg(CAL_MODE_ADDR, "mode_rd");
      rd_reg(8'($random(seed)), "other_rd");
    end
    $display("test register access done");
    for (int m = 0; m < 16; m++)
    begin
      wr_reg(CAL_MODE_ADDR, m[7:0]);
      cap = model_reg;
      en = 1'b1;
      n = 0;
      while (clr !== 1'b1 && n < 12)
      begin
        n++;
        step;
      end
      run_len(0, n);
      chk("clear_len", CLR[7:0], n[7:0]);
      chk("fg_run", {7'b0, cap[0]}, {7'b0, fgr});
      chk("fg_os", {7'b0, cap[0] & cap[2]}, {7'b0, fgo});
      if (cap[0])
      begin
        run_len(1, n);
        chk("fg_len", FGC[7:0], n[7:0]);
      end
      // a mid-run rewrite must not reach the running mode
      wr_reg(CAL_MODE_ADDR, ~cap & 8'h0f);
      step;
      chk("bg_on", {7'b0, cap[1]}, {7'b0, bgn});
      chk("bg_os", {7'b0, cap[1] & cap[3]}, {7'b0, bgo});
      chk("fg_idle", 8'h00, {7'b0, fgr});
      if (cap[0]) chk("fg_done", 8'h01, {7'b0, done});
      rd_reg(CAL_MODE_ADDR, "mode_rd");
      en = 1'b0;
      repeat (5) step;
      chk("held", 8'h00, {2'b00, clr, fgr, fgo, bgn, bgo, done});
      $display("test mode %0d done", m);
    end
    conclude;
  end
endmodule // cal_mode_config_tb_top
